//--- hdl/idio_port.sv
/*
  Register block of an eight-output, eight-input isolated digital I/O port,
  reached by host I/O read and write cycles inside a four-byte window.
  Assumes io_rd and io_wr are one-cycle strobes synchronous to clk, and
  that the base address and enable come from the configuration logic.
*/
`timescale 1ns/1ps
module idio_port
  import idio_pkg::*;
(
  input  wire logic [IO_ADDR_W-1:0] cfg_base_addr,
  input  wire logic                 cfg_enable,
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [IO_ADDR_W-1:0] io_addr,
  input  wire logic                 io_rd,
  input  wire logic                 io_wr,
  input  wire logic [DATA_W-1:0]    io_wr_data,
  output logic      [DATA_W-1:0]    io_rd_data,
  output logic                      io_rd_valid,
  input  wire logic [DATA_W-1:0]    isolated_input_line,
  output logic      [DATA_W-1:0]    isolated_output_line,
  output logic                      isolated_output_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  logic              window_hit;
  logic [1:0]        offset;
  logic              wr_output;
  logic              wr_direction;
  logic              rd_access;
  logic              dir_word_ok;
  logic [DATA_W-1:0] output_data;

  // Window placed wherever configuration put it; disabled means deaf
  assign window_hit = cfg_enable
                   && (io_addr[IO_ADDR_W-1:WIN_LSB] == cfg_base_addr[IO_ADDR_W-1:WIN_LSB]);
  assign offset     = io_addr[1:0];
  assign wr_output    = window_hit && io_wr && (offset == OFS_OUTPUT_PORT_DATA);
  assign wr_direction = window_hit && io_wr
                     && (offset == OFS_PORT_DIRECTION_CONTROL);
  assign rd_access    = window_hit && io_rd;

  // Only the documented mode word turns the output port on
  assign dir_word_ok = (io_wr_data & DIR_CHECK_MASK) == DIR_CHECK_MATCH;

  ////////////////////////////////////////////////////////////////////////////
  // Direction state
  logic out_mode_reg;

  // Any direction write restarts the ports; a bad word leaves outputs off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_mode_reg <= 1'b0;
    end else if (wr_direction) begin
      out_mode_reg <= dir_word_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output data latch
  idio_byte_reg #(
    .RESET_VALUE (OUTPUT_DATA_RESET)
  ) u_output_data (
    .clk   (clk),
    .nrst  (nrst),
    .clear (wr_direction),
    .load  (wr_output),
    .d     (io_wr_data),
    .q     (output_data)
  );

  // Lines follow the latch bit for bit; undriven until configured
  assign isolated_output_line = output_data;
  assign isolated_output_en   = out_mode_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [DATA_W-1:0] rd_data_reg;
  logic              rd_valid_reg;

  // Inputs are sampled only at the read itself; nothing is polled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_reg <= READ_IDLE_VALUE;
    end else if (rd_access) begin
      unique case (offset)
        OFS_OUTPUT_PORT_DATA: rd_data_reg <= output_data;
        // Open inputs already arrive low from the field side; no pull is added here
        OFS_INPUT_PORT_DATA:  rd_data_reg <= isolated_input_line;
        OFS_UNUSED_PORT:      rd_data_reg <= UNUSED_READ_VALUE;
        OFS_PORT_DIRECTION_CONTROL: rd_data_reg <= UNUSED_READ_VALUE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_access;
    end
  end

  assign io_rd_data  = rd_data_reg;
  assign io_rd_valid = rd_valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_dir_write;
    wr_direction;
  endsequence

  sequence s_ports_cleared;
    (output_data == OUTPUT_DATA_RESET) && (isolated_output_line == OUTPUT_DATA_RESET);
  endsequence

  sequence s_out_read;
    rd_access && (offset == OFS_OUTPUT_PORT_DATA);
  endsequence

  sequence s_in_read;
    rd_access && (offset == OFS_INPUT_PORT_DATA);
  endsequence

  property p_out_write;
    wr_output |=> (isolated_output_line == $past(io_wr_data));
  endproperty
  a_out_write: assert property (p_out_write)
    else $error("output line state differs from the byte written");

  property p_out_bits;
    wr_output ##1 !wr_output && !wr_direction |=>
      (isolated_output_line == $past(io_wr_data, 2));
  endproperty
  a_out_bits: assert property (p_out_bits)
    else $error("output lines did not hold the written byte");

  property p_out_read;
    s_out_read |=> io_rd_valid && (io_rd_data == $past(output_data));
  endproperty
  a_out_read: assert property (p_out_read)
    else $error("output register read did not return the line state");

  property p_in_read;
    s_in_read |=> io_rd_valid && (io_rd_data == $past(isolated_input_line));
  endproperty
  a_in_read: assert property (p_in_read)
    else $error("input register read did not return the input lines");

  property p_in_readonly;
    window_hit && io_wr && (offset == OFS_INPUT_PORT_DATA) |=>
      $stable(output_data) && $stable(out_mode_reg);
  endproperty
  a_in_readonly: assert property (p_in_readonly)
    else $error("write to the input register changed port state");

  property p_dir_mode;
    s_dir_write |=> (isolated_output_en == $past(dir_word_ok));
  endproperty
  a_dir_mode: assert property (p_dir_mode)
    else $error("direction write did not set the output enable as expected");

  property p_dir_reset;
    s_dir_write |=> s_ports_cleared;
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("direction write left output state behind");

  property p_unused_port;
    window_hit && (offset == OFS_UNUSED_PORT) |=>
      $stable(output_data) && $stable(out_mode_reg);
  endproperty
  a_unused_port: assert property (p_unused_port)
    else $error("access to the unused offset changed port state");

  property p_outside_window;
    !window_hit |=> !io_rd_valid && $stable(output_data) && $stable(out_mode_reg);
  endproperty
  a_outside_window: assert property (p_outside_window)
    else $error("access outside the assigned window had an effect");

  property p_read_only_on_access;
    io_rd_valid |-> $past(rd_access);
  endproperty
  a_read_only_on_access: assert property (p_read_only_on_access)
    else $error("read answer appeared without a host read");

  // Read data must not drift between host reads, or polling would be implied
  property p_rd_data_hold;
    !rd_access |=> $stable(io_rd_data);
  endproperty
  a_rd_data_hold: assert property (p_rd_data_hold)
    else $error("read data changed without a host read");

  property p_en_hold;
    !wr_direction |=> $stable(isolated_output_en);
  endproperty
  a_en_hold: assert property (p_en_hold)
    else $error("output enable changed without a direction write");

endmodule : idio_port

//--- hdl/idio_pkg.sv
/*
  Constants for the isolated digital I/O port: register offsets, the
  direction word layout, reset values and address widths.
  Assumes a host I/O bus with byte-wide data and 16-bit I/O addresses.
*/
package idio_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Host I/O address space
  localparam int unsigned IO_ADDR_W  = 16;
  localparam int unsigned WIN_LSB    = 2;
  localparam int unsigned DATA_W     = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets within the four-byte window
  localparam logic [1:0] OFS_OUTPUT_PORT_DATA       = 2'h0;
  localparam logic [1:0] OFS_INPUT_PORT_DATA        = 2'h1;
  localparam logic [1:0] OFS_UNUSED_PORT            = 2'h2;
  localparam logic [1:0] OFS_PORT_DIRECTION_CONTROL = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Direction word: bits 7 and 1 one, bits 6..4 and 2 zero, 3 and 0 free
  localparam int unsigned DIRECTION_WORD_BIT_MODE_SET = 7;
  localparam logic [7:0]  DIR_CHECK_MASK  = 8'hF6;
  localparam logic [7:0]  DIR_CHECK_MATCH = 8'h82;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and fixed read values
  localparam logic [7:0] OUTPUT_DATA_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE_VALUE   = 8'h00;
  localparam logic [7:0] UNUSED_READ_VALUE = 8'h00;

endpackage : idio_pkg

//--- hdl/idio_byte_reg.sv
/*
  Byte-wide storage cell with synchronous clear and load.
  Assumes clear and load come from the same clock domain; clear wins.
*/
`timescale 1ns/1ps
module idio_byte_reg
  import idio_pkg::*;
#(
  parameter logic [DATA_W-1:0] RESET_VALUE = OUTPUT_DATA_RESET
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              clear,
  input  wire logic              load,
  input  wire logic [DATA_W-1:0] d,
  output logic      [DATA_W-1:0] q
);

  logic [DATA_W-1:0] q_reg;

  // Clear has priority so a reconfigure never leaves stale data behind
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q_reg <= RESET_VALUE;
    end else if (clear) begin
      q_reg <= RESET_VALUE;
    end else if (load) begin
      q_reg <= d;
    end
  end

  assign q = q_reg;

endmodule : idio_byte_reg

//--- test/idio_field_model.sv
/*
  Field side of the isolated port: sensors feeding the input lines.
  Assumes the bench sets the sensed pattern and whether it is wired up.
*/
`timescale 1ns/1ps
module idio_field_model
  import idio_pkg::*;
(
  input  wire logic              connected,
  input  wire logic [DATA_W-1:0] pattern,
  output logic      [DATA_W-1:0] in_line
);
  // Open sensor inputs sense low; bit n of the pattern is line n
  assign in_line = connected ? pattern : 8'h00;
endmodule : idio_field_model

//--- test/test_idio_port.sv
/*
  Self-checking bench for the isolated port register block.
  Assumes the io strobes are taken one edge after they are driven.
*/
`timescale 1ns/1ps
module test_idio_port
  import idio_pkg::*;
;
  localparam logic [15:0] BASE = 16'h0240;
  logic              clk, nrst, io_rd, io_wr, io_rd_valid, out_en, conn, cfg_en;
  logic [15:0]       io_addr;
  logic [DATA_W-1:0] wdat, rdat, in_line, out_line, pat;
  int                mismatches, check_count, cycles;

  idio_port dut_u (.cfg_base_addr(BASE), .cfg_enable(cfg_en), .clk(clk), .nrst(nrst),
    .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wr_data(wdat),
    .io_rd_data(rdat), .io_rd_valid(io_rd_valid), .isolated_input_line(in_line),
    .isolated_output_line(out_line), .isolated_output_en(out_en));
  idio_field_model field_u (.connected(conn), .pattern(pat), .in_line(in_line));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    io_wr   <= 1'b1;
    io_addr <= a;
    wdat    <= d;
    @(posedge clk);
    io_wr <= 1'b0;
    #1;
  endtask : wr

  // Valid must stand exactly in the cycle after the taking edge
  task automatic rd(input logic [15:0] a, input logic hit, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    io_rd   <= 1'b1;
    io_addr <= a;
    @(posedge clk);
    io_rd <= 1'b0;
    #1;
    check({7'h00, io_rd_valid}, {7'h00, hit});
    if (hit) check(rdat, exp);
  endtask : rd

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Whole run is well under a few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    mismatches = 0; check_count = 0; cycles = 0;
    nrst = 1'b0; io_rd = 1'b0; io_wr = 1'b0; io_addr = BASE;
    wdat = 8'h00; conn = 1'b1; pat = 8'hA5;
    cfg_en = 1'b1;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    #1;
    check({7'h00, out_en}, 8'h00);
    wr(BASE + 16'h0003, 8'h82);
    check({7'h00, out_en}, 8'h01);
    wr(BASE, 8'h5A);
    check(out_line, 8'h5A);
    rd(BASE, 1'b1, 8'h5A);
    // Not bit-symmetric, so swapped line wiring shows up
    wr(BASE, 8'h13);
    check(out_line, 8'h13);
    rd(BASE + 16'h0001, 1'b1, 8'hA5);
    wr(BASE + 16'h0001, 8'hFF);
    wr(BASE + 16'h0002, 8'h00);
    check(out_line, 8'h13);
    rd(BASE + 16'h0002, 1'b1, 8'h00);
    rd(BASE + 16'h0004, 1'b0, 8'h00);
    wr(BASE + 16'h0007, 8'h82);
    check(out_line, 8'h13);
    // Window switched off: the port must ignore even a legal address
    @(posedge clk);
    cfg_en <= 1'b0;
    rd(BASE, 1'b0, 8'h00);
    wr(BASE + 16'h0003, 8'h80);
    check(out_line, 8'h13);
    check({7'h00, out_en}, 8'h01);
    @(posedge clk);
    cfg_en <= 1'b1;
    wr(BASE + 16'h0003, 8'h8B);
    check(out_line, 8'h00);
    check({7'h00, out_en}, 8'h01);
    wr(BASE, 8'h3C);
    wr(BASE + 16'h0003, 8'h80);
    check(out_line, 8'h00);
    check({7'h00, out_en}, 8'h00);
    rd(BASE + 16'h0003, 1'b1, 8'h00);
    pat = 8'h01;
    rd(BASE + 16'h0001, 1'b1, 8'h01);
    conn = 1'b0;
    rd(BASE + 16'h0001, 1'b1, 8'h00);
    conclude();
  end
endmodule : test_idio_port
